//--- src/lic_config.sv
// module: left line input routing config registers behind an apb slave
//
// How it works
// - codes 0..8 give 0 to -12 dB
// - valid code on input one connects it
// - all-ones code leaves input disconnected
// - input one bit 7 selects differential
// - input two bit 7 selects differential
// - bits 6..3 hold level, reset all-ones
// - input one bit 2 powers channel up
// - input one bits 1..0 pick stepping rate
// - input two bit 2 enables weak bias
// - input two bits 1..0 read-only zero
`timescale 1ns/100ps
module lic_config #(
  parameter int unsigned fs_cycles = lic_pkg::fs_cycles
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // line input controls to the analogue mixer
  output lic_pkg::lic_line_type first_left_line_input,
  output lic_pkg::lic_line_type second_left_line_input,
  // left channel controls
  output logic left_power_up,
  output logic left_weak_bias,
  output logic [1:0] left_soft_mode,
  output logic [6:0] left_pga_gain
);

  // ==========================================
  // state
  lic_pkg::lic_state_type s;
  lic_pkg::lic_state_type next_s;
  lic_pkg::lic_sel_type sel;
  logic fs_tick;
  logic [6:0] gain_now;
  logic access;
  logic commit;

  assign sel = lic_pkg::decode_addr(paddr);
  // answer takes one wait cycle so read data leave a flop
  assign access = psel & penable & ~s.pready;
  assign commit = psel & penable & s.pready & pwrite & ~s.pslverr;

  // ==========================================
  // bus and register update
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (access) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (sel == lic_pkg::sel_one) begin
        next_s.prdata[7:0] = s.route_one;
      end else if (sel == lic_pkg::sel_two) begin
        next_s.prdata[7:0] = s.route_two & lic_pkg::ro_mask_two;
      end else if (sel == lic_pkg::sel_target) begin
        next_s.prdata[6:0] = s.gain_target;
      end else if (sel == lic_pkg::sel_now) begin
        next_s.prdata[6:0] = gain_now;
      end else begin
        // unmapped address answers with an error
        next_s.pslverr = 1'b1;
      end
    end
    // writes land only on the completing edge, low byte lane
    if (commit && pstrb[0]) begin
      if (sel == lic_pkg::sel_one) begin
        next_s.route_one = pwdata[7:0];
      end else if (sel == lic_pkg::sel_two) begin
        next_s.route_two = pwdata[7:0] & lic_pkg::ro_mask_two;
      end else if (sel == lic_pkg::sel_target) begin
        next_s.gain_target = pwdata[6:0];
      end
    end
    // decode from the new values, same edge
    next_s.line_one = lic_pkg::decode_line(next_s.route_one);
    next_s.line_two = lic_pkg::decode_line(next_s.route_two);
    next_s.power_up = next_s.route_one[lic_pkg::power_pos];
    next_s.weak_bias = next_s.route_two[lic_pkg::bias_pos];
  end

  // ==========================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      s.route_one <= lic_pkg::route_reset;
      s.route_two <= lic_pkg::route_reset;
      s.gain_target <= lic_pkg::gain_reset;
      s.line_one <= '{diff: 1'b0, connect: 1'b0, atten: 5'h00};
      s.line_two <= '{diff: 1'b0, connect: 1'b0, atten: 5'h00};
      s.power_up <= 1'b0;
      s.weak_bias <= 1'b0;
      s.pready <= 1'b0;
      s.pslverr <= 1'b0;
      s.prdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // soft-step engine
  lic_fs_tick #(
    .fs_cycles(fs_cycles)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .fs_tick(fs_tick)
  );

  // gain moves one step per selected tick
  lic_gain_step u_step (
    .clock(clock),
    .rst(rst),
    .fs_tick(fs_tick),
    .soft_mode(s.route_one[lic_pkg::soft_hi:0]),
    .target(s.gain_target),
    .gain_now(gain_now)
  );

  // ==========================================
  // outputs
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign first_left_line_input = s.line_one;
  assign second_left_line_input = s.line_two;
  assign left_power_up = s.power_up;
  assign left_weak_bias = s.weak_bias;
  // soft mode is the register field itself
  assign left_soft_mode = s.route_one[lic_pkg::soft_hi:0];
  assign left_pga_gain = gain_now;

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence setup_seq;
    psel && !penable;
  endsequence

  sequence wait_seq;
    psel && penable && !pready;
  endsequence

  sequence done_seq;
    psel && penable && pready;
  endsequence

  // access answers after one wait cycle
  apb_answer_a: assert property (setup_seq ##1 wait_seq |=> done_seq)
    else $error("apb answer not one cycle after access");

  // pready is a single cycle
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  atten_scale_a: assert property (##1 first_left_line_input.connect
    |-> first_left_line_input.atten == 5'(s.route_one[6:3] * 3))
    else $error("attenuation not 1.5 dB per code");

  write_connect_a: assert property (commit && pstrb[0] && sel == lic_pkg::sel_one && pwdata[6:3] <= 4'h8
    |=> first_left_line_input.connect)
    else $error("valid level did not connect input one");

  off_code_a: assert property (s.route_two[6:3] == 4'hf |-> !second_left_line_input.connect)
    else $error("all-ones level left input two connected");

  diff_one_a: assert property (##1 first_left_line_input.diff == s.route_one[7])
    else $error("input one diff select wrong");

  diff_two_a: assert property (commit && pstrb[0] && sel == lic_pkg::sel_two
    |=> second_left_line_input.diff == $past(pwdata[7]))
    else $error("input two diff select wrong");

  level_reset_a: assert property ($fell(rst) |-> !first_left_line_input.connect
    && !second_left_line_input.connect)
    else $error("inputs not disconnected after reset");

  power_follow_a: assert property (commit && pstrb[0] && sel == lic_pkg::sel_one
    |=> left_power_up == $past(pwdata[2]))
    else $error("power control did not follow write");

  step_off_a: assert property (left_soft_mode[1]
    ##1 left_soft_mode[1] && $stable(s.gain_target) |-> left_pga_gain == s.gain_target)
    else $error("gain not direct with stepping off");

  weak_bias_a: assert property (##1 left_weak_bias == s.route_two[2])
    else $error("weak bias does not match field");

  ro_bits_a: assert property (s.route_two[1:0] == 2'h0)
    else $error("read-only bits not zero");

  one_step_a: assert property (!left_soft_mode[1] && $changed(left_pga_gain)
    |-> (left_pga_gain == $past(left_pga_gain) + 7'h01)
    || (left_pga_gain == $past(left_pga_gain) - 7'h01))
    else $error("gain jumped more than one step");

  step_rate_a: assert property (left_soft_mode == lic_pkg::soft_once && $changed(left_pga_gain)
    ##1 left_soft_mode == lic_pkg::soft_once |-> $stable(left_pga_gain) [*7])
    else $error("gain stepped faster than sample rate");

endmodule : lic_config

//--- src/lic_fs_tick.sv
// module: sample-rate enable pulse from the system clock
`timescale 1ns/100ps
module lic_fs_tick #(
  parameter int unsigned fs_cycles = lic_pkg::fs_cycles
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // one-cycle pulse per sample period
  output logic fs_tick
);

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } lic_tick_type;

  lic_tick_type s;
  lic_tick_type next_s;

  // count down one sample period, pulse on wrap
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == 16'h0000) begin
      next_s.count = 16'(fs_cycles - 1);
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fs_tick = s.tick;

endmodule : lic_fs_tick

//--- src/lic_gain_step.sv
// module: left gain soft-stepper toward a target setting
`timescale 1ns/100ps
module lic_gain_step (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // step control
  input wire logic fs_tick,
  input wire logic [1:0] soft_mode,
  input wire logic [6:0] target,
  // applied gain
  output logic [6:0] gain_now
);

  typedef struct packed {
    logic [6:0] gain;
    logic half;
  } lic_step_type;

  lic_step_type s;
  lic_step_type next_s;
  logic step_ok;

  // half toggles per sample so mode 01 steps every second sample
  always_comb begin
    next_s = s;
    step_ok = 1'b0;
    if (fs_tick) begin
      next_s.half = ~s.half;
    end
    if (soft_mode == lic_pkg::soft_once) begin
      step_ok = fs_tick;
    end else if (soft_mode == lic_pkg::soft_twice) begin
      step_ok = fs_tick & s.half;
    end
    if (soft_mode[1]) begin
      next_s.gain = target;
    end else if (step_ok && s.gain < target) begin
      next_s.gain = s.gain + 7'h01;
    end else if (step_ok && s.gain > target) begin
      next_s.gain = s.gain - 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '{gain: lic_pkg::gain_reset, half: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign gain_now = s.gain;

endmodule : lic_gain_step

//--- src/lic_pkg.sv
// package: constants, types and decode helpers of the left line input config block
package lic_pkg;

  // ==========================================
  // clock and sample timing
  localparam int unsigned clock_hz = 250_000_000;
  localparam int unsigned sample_hz = 48_000;
  // whole cycles per sample period, rounded down
  localparam int unsigned fs_cycles = clock_hz / sample_hz;

  // ==========================================
  // register indexes; byte address is four times the index
  localparam logic [7:0] idx_one_route = 8'h13;
  localparam logic [7:0] idx_two_route = 8'h14;
  localparam logic [7:0] idx_gain_target = 8'h15;
  localparam logic [7:0] idx_gain_now = 8'h16;

  // ==========================================
  // field positions
  localparam int unsigned diff_pos = 7;
  localparam int unsigned level_hi = 6;
  localparam int unsigned level_lo = 3;
  localparam int unsigned power_pos = 2;
  localparam int unsigned bias_pos = 2;
  localparam int unsigned soft_hi = 1;

  // ==========================================
  // reset values and codes
  localparam logic [7:0] route_reset = 8'h78;
  localparam logic [6:0] gain_reset = 7'h00;
  localparam logic [3:0] level_off = 4'hf;
  localparam logic [3:0] level_max = 4'h8;
  localparam logic [1:0] soft_once = 2'h0;
  localparam logic [1:0] soft_twice = 2'h1;
  localparam logic [7:0] ro_mask_two = 8'hfc;

  // ==========================================
  // types
  typedef enum logic [2:0] {sel_one, sel_two, sel_target, sel_now, sel_none} lic_sel_type;

  typedef struct packed {
    logic diff;
    logic connect;
    logic [4:0] atten;
  } lic_line_type;

  typedef struct packed {
    logic [7:0] route_one;
    logic [7:0] route_two;
    logic [6:0] gain_target;
    lic_line_type line_one;
    lic_line_type line_two;
    logic power_up;
    logic weak_bias;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lic_state_type;

  // ==========================================
  // level code to attenuation in 0.5 dB units, 1.5 dB per code
  function automatic lic_line_type decode_line(input logic [7:0] route);
    lic_line_type r;
    r.diff = route[diff_pos];
    r.connect = (route[level_hi:level_lo] <= level_max);
    r.atten = r.connect ? 5'(route[level_hi:level_lo] * 3) : 5'h00;
    return r;
  endfunction : decode_line

  // byte address decode
  function automatic lic_sel_type decode_addr(input logic [11:0] paddr);
    if (paddr == {2'h0, idx_one_route, 2'h0}) begin
      return sel_one;
    end else if (paddr == {2'h0, idx_two_route, 2'h0}) begin
      return sel_two;
    end else if (paddr == {2'h0, idx_gain_target, 2'h0}) begin
      return sel_target;
    end else if (paddr == {2'h0, idx_gain_now, 2'h0}) begin
      return sel_now;
    end else begin
      return sel_none;
    end
  endfunction : decode_addr

endpackage : lic_pkg

//--- test/lic_config_tb.sv
// testbench: register map, level decode, control bits and soft-step checks of the line input config block
`timescale 1ns/100ps
module left_adc_line_input_config_tb_top;
  // ==========================================
  // short sample period keeps the stepping runs brief
  localparam int unsigned fs_sim = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  lic_pkg::lic_line_type line_one;
  lic_pkg::lic_line_type line_two;
  logic power_up;
  logic weak_bias;
  logic [1:0] soft_mode;
  logic [6:0] pga_gain;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int n_tests = 0;

  // free-running clock
  always #2 clock = ~clock;

  lic_config #(.fs_cycles(fs_sim)) dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .first_left_line_input(line_one), .second_left_line_input(line_two), .left_power_up(power_up),
    .left_weak_bias(weak_bias), .left_soft_mode(soft_mode), .left_pga_gain(pga_gain)
  );

  // ==========================================
  // shared helpers
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; waits on pready, bounded so a dead slave cannot hang us
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic got;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // look just after an edge: the registered answer stands through the next edge, which completes it
    do begin
      #1;
      n++;
      got = pready;
      rd = prdata;
      err = pslverr;
      @(posedge clock);
    end while (got !== 1'b1 && n < 20);
    if (got !== 1'b1) begin
      errors++;
      $display("Error at %0t: no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // let the edge's updates land before looking
  task settle;
    @(posedge clock);
    #1;
  endtask : settle

  // expected mixer control: 1.5 dB per code in 0.5 dB units
  function automatic logic [6:0] line_exp(input logic d, input logic [3:0] c);
    return (c <= 4'h8) ? {d, 1'b1, 5'(c * 3)} : {d, 1'b0, 5'h00};
  endfunction : line_exp

  // ==========================================
  // scenarios
  task t_reset;
    apb(1'b0, 12'h04c, 32'h0, 4'hf);
    chk(rd, 32'h0000_0078, "route one reset");
    apb(1'b0, 12'h050, 32'h0, 4'hf);
    chk(rd, 32'h0000_0078, "route two reset");
    chk(32'({line_one, line_two}), 32'h0, "lines after reset");
    chk(32'({power_up, weak_bias, soft_mode, pga_gain}), 32'h0, "controls after reset");
    $display("done: reset");
  endtask : t_reset

  task t_levels;
    logic [3:0] c;
    logic [11:0] a;
    for (int k = 0; k < 2; k++) begin
      a = (k == 0) ? 12'h04c : 12'h050;
      for (int i = 0; i < 10; i++) begin
        // reserved codes 9 to 14 never written
        c = (i == 9) ? 4'hf : 4'(i);
        apb(1'b1, a, {24'h0, i[0], c, 3'h0}, 4'hf);
        settle();
        chk(32'((k == 0) ? line_one : line_two), 32'(line_exp(i[0], c)), "level decode");
        apb(1'b0, a, 32'h0, 4'hf);
        chk(rd, {24'h0, i[0], c, 3'h0}, "level readback");
      end
    end
    $display("done: levels");
  endtask : t_levels

  task t_flags;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h04c, 32'h84 | m, 4'hf);
      settle();
      chk(32'({power_up, soft_mode}), 32'h4 | m, "power and step mode");
    end
    apb(1'b1, 12'h04c, 32'h78, 4'hf);
    settle();
    chk(32'(power_up), 32'h0, "power down");
    apb(1'b1, 12'h050, 32'hff, 4'hf);
    settle();
    chk(32'(weak_bias), 32'h1, "bias on");
    apb(1'b0, 12'h050, 32'h0, 4'hf);
    chk(rd, 32'hfc, "low bits read zero");
    apb(1'b1, 12'h050, 32'h78, 4'hf);
    settle();
    chk(32'(weak_bias), 32'h0, "bias off");
    $display("done: flags");
  endtask : t_flags

  task t_bus;
    apb(1'b1, 12'h060, 32'hff, 4'hf);
    chk(32'(err), 32'h1, "unmapped write error");
    apb(1'b0, 12'h060, 32'h0, 4'hf);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    // strobe off leaves the register alone
    apb(1'b1, 12'h04c, 32'h0, 4'he);
    apb(1'b0, 12'h04c, 32'h0, 4'hf);
    chk({rd[30:0], err}, 32'hf0, "strobe-off write ignored");
    $display("done: bus");
  endtask : t_bus

  // mode 00 one code per tick, mode 01 one per two ticks; never jumps
  task t_step;
    int cnt;
    int p;
    logic [6:0] prev;
    for (int m = 0; m < 2; m++) begin
      p = fs_sim * (m + 1);
      apb(1'b1, 12'h04c, 32'h7b, 4'hf);
      apb(1'b1, 12'h054, 32'h0a, 4'hf);
      settle();
      chk(32'(pga_gain), 32'h0a, "disabled stepping jumps");
      apb(1'b1, 12'h04c, 32'h78 | m, 4'hf);
      apb(1'b1, 12'h054, 32'h0, 4'hf);
      cnt = 0;
      prev = 7'h0a;
      while (pga_gain !== 7'h00 && cnt < 400) begin
        settle();
        cnt++;
        if (prev - pga_gain > 7'h01) begin
          errors++;
          $display("Error at %0t: gain jumped", $time);
        end
        prev = pga_gain;
      end
      chk(32'(cnt >= 9 * p && cnt <= 11 * p + 4), 32'h1, "stepping rate");
    end
    apb(1'b0, 12'h058, 32'h0, 4'hf);
    chk(rd, 32'h0, "applied gain readback");
    $display("done: step");
  endtask : t_step

  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_levels();
    t_flags();
    t_bus();
    t_step();
    close_out();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #60000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : left_adc_line_input_config_tb_top
